// [hdl/ppip_host.sv]
/*
  host-side checker and parser for the target's parameter page and extended page.
  assumes bytes arrive in increasing offset order, one per byte_valid_in cycle,
  and that software starts a pass before the fetch begins.
*/
// Functional notes
// - checksum covers primary bytes 0 through 253
// - bytes fed in order, bit 7 first
// - generator polynomial 8005h
// - checksum preset 4F4Eh before first byte
// - no final xor, no bit reversal
// - first backup copy used on primary failure
// - second backup used when first two fail
// - further copy present if two signature bytes match
// - vendor revision kept; vendor bytes not interpreted
// - extended sections are 16-byte multiples
// - types: 0 none, 1 specifiers, 2 ecc
// - ascending unique types, stop at type 0
// - type 1 needed beyond eight sections; code flags any full eight-entry table without it
// - extended checksum, signature, reserved zero header
// - section table bytes 16-31, content from 32
// - multi-byte fields are little endian
// - section length counts 16-byte units
// - extended checksum covers byte 2 to end
`timescale 1ns/1ps
module ppip_host (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // software register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  // byte stream from the target
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  // summary
  output logic busy_out,
  output logic done_out,
  output logic pass_out,
  output ppip_pkg::ppip_caps_s caps_out
);
  import ppip_pkg::*;

  // ==========================================================
  // declarations
  ppip_state_e state;
  ppip_status_s stat;
  logic ext_mode;
  logic [15:0] ext_len;
  logic [15:0] off;
  logic [2:0] sig_cnt;
  logic [7:0] crc_lo;
  logic [15:0] crc_stored;
  logic [15:0] crc_val;
  logic ext_fin;
  ppip_caps_s shadow;
  logic stopped;
  logic seen_spec;
  logic [7:0] prev_type;
  logic [7:0] cur_type;
  logic [15:0] run;
  logic [15:0] ecc_start;
  logic ecc_valid;
  logic [15:0] spec_start;
  logic spec_valid;
  logic [7:0] ecc_blk [0:7];
  logic [63:0] ecc_word;
  logic [7:0] sec8_type;
  logic [7:0] sec8_len;
  logic start;
  logic take_pri;
  logic take_ext;
  logic [7:0] poff;
  logic [2:0] sig_now;
  logic [15:0] ecc_rel;
  logic crc_clr;
  logic crc_en;

  // ==========================================================
  // decode helpers
  function automatic logic sig_hit(input logic [31:0] sig, input logic [1:0] idx, input logic [7:0] b);
    return b == sig[{idx, 3'b000} +: 8];
  endfunction

  always_comb
  begin
    start = ce_in & wr_in & (addr_in == REG_CTRL) & wr_data_in[CTRL_START_BIT];
    take_pri = ce_in & byte_valid_in & (state == ST_PRI);
    take_ext = ce_in & byte_valid_in & (state == ST_EXT) & ~ext_fin;
    poff = off[7:0];
    ecc_rel = off - ecc_start;
    if (state == ST_PRI)
    begin
      sig_now = ((poff == OFF_FIRST) ? 3'h0 : sig_cnt) + {2'b00, sig_hit(PAGE_SIG, poff[1:0], byte_in)};
    end
    else
    begin
      sig_now = ((off == EXT_OFF_SIG_FIRST) ? 3'h0 : sig_cnt)
        + {2'b00, sig_hit(EXT_SIG, 2'(off - EXT_OFF_SIG_FIRST), byte_in)};
    end
    crc_clr = (take_pri & (poff == OFF_FIRST)) | (take_ext & (off == EXT_OFF_SIG_FIRST));
    crc_en = (take_pri & (poff <= OFF_LAST_COVERED)) | (take_ext & (off >= EXT_OFF_SIG_FIRST));
  end

  ppip_crc16 u_crc (
    .core_clk_in (core_clk_in),
    .rst_in (rst_in),
    .ce_in (ce_in),
    .clr_in (crc_clr),
    .en_in (crc_en),
    .byte_in (byte_in),
    .crc_out (crc_val)
  );

  // ==========================================================
  // software-written configuration
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ext_mode <= 1'b0;
      ext_len <= EXT_LEN_RESET;
    end
    else if (ce_in & wr_in)
    begin
      if (addr_in == REG_CTRL)
      begin
        ext_mode <= wr_data_in[CTRL_EXT_BIT];
      end
      if (addr_in == REG_EXT_LEN)
      begin
        ext_len <= wr_data_in[15:0];
      end
    end
  end

  // ==========================================================
  // read port, data valid in the cycle after the strobe
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_data_out <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      rd_data_out <= 32'h0000_0000;
      if (rd_in)
      begin
        case (addr_in)
          REG_CTRL: rd_data_out <= {30'h0, ext_mode, 1'b0};
          REG_EXT_LEN: rd_data_out <= {16'h0000, ext_len};
          REG_STATUS: rd_data_out <= {16'h0000, stat};
          REG_DRIVE: rd_data_out <= {29'h0, caps_out.drive};
          REG_RDTIME: rd_data_out <= {16'h0000, caps_out.read_time};
          REG_VREV: rd_data_out <= {16'h0000, caps_out.vrev};
          REG_CRC: rd_data_out <= {crc_stored, crc_val};
          REG_ECC_LO: rd_data_out <= ecc_word[31:0];
          REG_ECC_HI: rd_data_out <= ecc_word[63:32];
          REG_SEC8: rd_data_out <= {16'h0000, sec8_len, sec8_type};
          default: rd_data_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // sequencer: offset, copy walk, verdict
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= ST_IDLE;
      off <= 16'h0000;
      ext_fin <= 1'b0;
      stat.copy_idx <= 8'h00;
      stat.pass <= 1'b0;
      stat.sig_err <= 1'b0;
      stat.done <= 1'b0;
      stat.busy <= 1'b0;
      done_out <= 1'b0;
      busy_out <= 1'b0;
      pass_out <= 1'b0;
    end
    else if (ce_in)
    begin
      done_out <= 1'b0;
      if (start)
      begin
        // the mode bit written with start picks the page, not the stored mode
        state <= wr_data_in[CTRL_EXT_BIT] ? ST_EXT : ST_PRI;
        off <= 16'h0000;
        ext_fin <= 1'b0;
        stat.copy_idx <= 8'h00;
        stat.pass <= 1'b0;
        stat.sig_err <= 1'b0;
        stat.done <= 1'b0;
        stat.busy <= 1'b1;
        busy_out <= 1'b1;
        pass_out <= 1'b0;
      end
      else if (take_pri)
      begin
        off <= off + 16'h0001;
        if ((poff == OFF_SIG_LAST) && (stat.copy_idx >= MAND_COPIES) && (sig_now < SIG_MIN_MATCH))
        begin
          // no further copy present: all copies failed
          state <= ST_DONE;
          stat.sig_err <= 1'b1;
          stat.done <= 1'b1;
          stat.busy <= 1'b0;
          busy_out <= 1'b0;
          done_out <= 1'b1;
        end
        else if (poff == OFF_CRC_HI)
        begin
          if (crc_val == {byte_in, crc_lo})
          begin
            state <= ST_DONE;
            stat.pass <= 1'b1;
            stat.done <= 1'b1;
            stat.busy <= 1'b0;
            busy_out <= 1'b0;
            pass_out <= 1'b1;
            done_out <= 1'b1;
          end
          else if (stat.copy_idx != 8'hFF)
          begin
            // fall back to the next copy in the stream
            stat.copy_idx <= stat.copy_idx + 8'h01;
          end
        end
      end
      else if (take_ext)
      begin
        off <= off + 16'h0001;
        if ((off == EXT_OFF_SIG_LAST) && (sig_now < SIG_MIN_MATCH))
        begin
          stat.sig_err <= 1'b1;
        end
        if (off == ext_len - 16'h0001)
        begin
          ext_fin <= 1'b1;
        end
      end
      else if (ext_fin)
      begin
        // checksum register holds the last byte only from this cycle on
        ext_fin <= 1'b0;
        state <= ST_DONE;
        stat.pass <= (crc_val == crc_stored) & ~stat.sig_err;
        pass_out <= (crc_val == crc_stored) & ~stat.sig_err;
        stat.done <= 1'b1;
        stat.busy <= 1'b0;
        busy_out <= 1'b0;
        done_out <= 1'b1;
      end
    end
  end

  // ==========================================================
  // stored checksum, signature count, capability capture
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      crc_lo <= 8'h00;
      crc_stored <= 16'h0000;
      sig_cnt <= 3'h0;
      shadow <= '0;
      caps_out <= '0;
    end
    else if (ce_in)
    begin
      if (start)
      begin
        crc_stored <= 16'h0000;
        sig_cnt <= 3'h0;
      end
      if (take_pri)
      begin
        if (poff <= OFF_SIG_LAST)
        begin
          sig_cnt <= sig_now;
        end
        case (poff)
          OFF_DRIVE: shadow.drive <= byte_in[2:0] & DRIVE_CAP_MASK;
          OFF_RDT_LO: shadow.read_time[7:0] <= byte_in;
          OFF_RDT_HI: shadow.read_time[15:8] <= byte_in;
          OFF_VREV_LO: shadow.vrev[7:0] <= byte_in;
          OFF_VREV_HI: shadow.vrev[15:8] <= byte_in;
          OFF_CRC_LO: crc_lo <= byte_in;
          OFF_CRC_HI: crc_stored <= {byte_in, crc_lo};
          default: crc_lo <= crc_lo;
        endcase
        // only a copy whose checksum matched may update the reported fields
        if ((poff == OFF_CRC_HI) && (crc_val == {byte_in, crc_lo}))
        begin
          caps_out <= shadow;
        end
      end
      if (take_ext)
      begin
        if (off == 16'h0000)
        begin
          crc_stored[7:0] <= byte_in;
        end
        if (off == EXT_OFF_CRC_HI)
        begin
          crc_stored[15:8] <= byte_in;
        end
        if ((off >= EXT_OFF_SIG_FIRST) && (off <= EXT_OFF_SIG_LAST))
        begin
          sig_cnt <= sig_now;
        end
      end
    end
  end

  // ==========================================================
  // extended header and section table walk
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stopped <= 1'b0;
      seen_spec <= 1'b0;
      prev_type <= SEC_NONE;
      cur_type <= SEC_NONE;
      run <= EXT_OFF_SECT;
      ecc_start <= 16'h0000;
      ecc_valid <= 1'b0;
      spec_start <= 16'h0000;
      spec_valid <= 1'b0;
      stat.rsvd_err <= 1'b0;
      stat.order_err <= 1'b0;
      stat.type1_missing <= 1'b0;
      stat.layout_err <= 1'b0;
    end
    else if (ce_in)
    begin
      if (start)
      begin
        stopped <= 1'b0;
        seen_spec <= 1'b0;
        prev_type <= SEC_NONE;
        cur_type <= SEC_NONE;
        run <= EXT_OFF_SECT;
        ecc_valid <= 1'b0;
        spec_valid <= 1'b0;
        stat.rsvd_err <= 1'b0;
        stat.order_err <= 1'b0;
        stat.type1_missing <= 1'b0;
        stat.layout_err <= 1'b0;
      end
      else if (take_ext)
      begin
        if ((off > EXT_OFF_SIG_LAST) && (off <= EXT_OFF_RSVD_LAST) && (byte_in != 8'h00))
        begin
          stat.rsvd_err <= 1'b1;
        end
        if ((off > EXT_OFF_RSVD_LAST) && (off <= EXT_OFF_TBL_LAST) && ~stopped)
        begin
          if (~off[0])
          begin
            cur_type <= byte_in;
            if (byte_in == SEC_NONE)
            begin
              stopped <= 1'b1;
            end
            else
            begin
              if (byte_in > SEC_ECC)
              begin
                stat.rsvd_err <= 1'b1;
              end
              if (byte_in <= prev_type)
              begin
                stat.order_err <= 1'b1;
              end
              prev_type <= byte_in;
              seen_spec <= seen_spec | (byte_in == SEC_SPEC);
            end
          end
          else
          begin
            run <= run + {4'h0, byte_in, 4'h0};
            if (byte_in == 8'h00)
            begin
              stat.layout_err <= 1'b1;
            end
            if (cur_type == SEC_ECC)
            begin
              ecc_start <= run;
              ecc_valid <= 1'b1;
            end
            if (cur_type == SEC_SPEC)
            begin
              spec_start <= run;
              spec_valid <= 1'b1;
            end
            if ((off == EXT_OFF_TBL_LAST) && ~seen_spec)
            begin
              stat.type1_missing <= 1'b1;
            end
          end
        end
        if ((off == ext_len - 16'h0001) && (off < EXT_OFF_TBL_LAST))
        begin
          stat.layout_err <= 1'b1;
        end
      end
      else if (ext_fin && (run > ext_len))
      begin
        stat.layout_err <= 1'b1;
      end
    end
  end

  // ==========================================================
  // section content capture: ecc block 0, section 8 specifier
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      for (int i = 0; i < 8; i++)
      begin
        ecc_blk[i] <= 8'h00;
      end
      sec8_type <= SEC_NONE;
      sec8_len <= 8'h00;
    end
    else if (ce_in)
    begin
      if (start)
      begin
        for (int i = 0; i < 8; i++)
        begin
          ecc_blk[i] <= 8'h00;
        end
        sec8_type <= SEC_NONE;
        sec8_len <= 8'h00;
      end
      else if (take_ext && (off >= EXT_OFF_SECT))
      begin
        if (ecc_valid && (off >= ecc_start) && (ecc_rel < ECC_BLK_BYTES))
        begin
          ecc_blk[ecc_rel[2:0]] <= byte_in;
        end
        if (spec_valid && (off == spec_start))
        begin
          sec8_type <= byte_in;
        end
        if (spec_valid && (off == spec_start + 16'h0001))
        begin
          sec8_len <= byte_in;
        end
      end
    end
  end

  // ecc block 0 read back as one little-endian doubleword pair
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_ecc
      assign ecc_word[8*g +: 8] = ecc_blk[g];
    end
  endgenerate

endmodule

// [shared/ppip_pkg.sv]
/*
  constants, types and register map of the parameter page integrity and parse host.
  assumes a byte stream from the flash target and a plain software register port.
*/
package ppip_pkg;

  // ==========================================================
  // checksum
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_PRESET = 16'h4F4E;

  // ==========================================================
  // primary page offsets within one 256-byte copy
  localparam logic [7:0] OFF_FIRST = 8'h00;
  localparam logic [7:0] OFF_SIG_LAST = 8'h03;
  localparam logic [7:0] OFF_DRIVE = 8'h97;
  localparam logic [7:0] OFF_RDT_LO = 8'h98;
  localparam logic [7:0] OFF_RDT_HI = 8'h99;
  localparam logic [7:0] OFF_VREV_LO = 8'hA4;
  localparam logic [7:0] OFF_VREV_HI = 8'hA5;
  localparam logic [7:0] OFF_LAST_COVERED = 8'hFD;
  localparam logic [7:0] OFF_CRC_LO = 8'hFE;
  localparam logic [7:0] OFF_CRC_HI = 8'hFF;
  localparam logic [7:0] MAND_COPIES = 8'h03;
  localparam logic [2:0] SIG_MIN_MATCH = 3'h2;
  localparam logic [2:0] DRIVE_CAP_MASK = 3'h7;
  // byte i of a signature sits at bits [8i+7:8i]
  localparam logic [31:0] PAGE_SIG = 32'h4946_4E4F;
  localparam logic [31:0] EXT_SIG = 32'h5450_5045;

  // ==========================================================
  // extended page offsets
  localparam logic [15:0] EXT_OFF_CRC_HI = 16'h0001;
  localparam logic [15:0] EXT_OFF_SIG_FIRST = 16'h0002;
  localparam logic [15:0] EXT_OFF_SIG_LAST = 16'h0005;
  localparam logic [15:0] EXT_OFF_RSVD_LAST = 16'h000F;
  localparam logic [15:0] EXT_OFF_TBL_LAST = 16'h001F;
  localparam logic [15:0] EXT_OFF_SECT = 16'h0020;
  localparam logic [15:0] ECC_BLK_BYTES = 16'h0008;
  localparam logic [7:0] SEC_NONE = 8'h00;
  localparam logic [7:0] SEC_SPEC = 8'h01;
  localparam logic [7:0] SEC_ECC = 8'h02;

  // ==========================================================
  // software registers
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_EXT_LEN = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_DRIVE = 8'h0C;
  localparam logic [7:0] REG_RDTIME = 8'h10;
  localparam logic [7:0] REG_VREV = 8'h14;
  localparam logic [7:0] REG_CRC = 8'h18;
  localparam logic [7:0] REG_ECC_LO = 8'h1C;
  localparam logic [7:0] REG_ECC_HI = 8'h20;
  localparam logic [7:0] REG_SEC8 = 8'h24;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam logic [15:0] EXT_LEN_RESET = 16'h0100;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRI = 2'b01,
    ST_EXT = 2'b10,
    ST_DONE = 2'b11
  } ppip_state_e;

  typedef struct packed {
    logic [2:0] drive;
    logic [15:0] read_time;
    logic [15:0] vrev;
  } ppip_caps_s;

  typedef struct packed {
    logic [7:0] copy_idx;
    logic layout_err;
    logic type1_missing;
    logic order_err;
    logic rsvd_err;
    logic sig_err;
    logic pass;
    logic done;
    logic busy;
  } ppip_status_s;

endpackage

// [hdl/ppip_crc16.sv]
/*
  byte-parallel 16-bit checksum engine, msb of each byte first.
  assumes the caller gives one byte per enabled cycle.
*/
`timescale 1ns/1ps
module ppip_crc16 (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // control and data
  input wire logic clr_in,
  input wire logic en_in,
  input wire logic [7:0] byte_in,
  // result
  output logic [15:0] crc_out
);
  import ppip_pkg::*;

  // ==========================================================
  // one byte step
  function automatic logic [15:0] crc_step(input logic [15:0] c_in, input logic [7:0] b);
    logic [15:0] c;
    logic fb;
    c = c_in;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      fb = c[15] ^ b[i];
      c = {c[14:0], 1'b0};
      if (fb)
      begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

  // ==========================================================
  // clear reloads the preset; clear with enable folds the first byte in
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      crc_out <= CRC_PRESET;
    end
    else if (ce_in)
    begin
      if (en_in)
      begin
        crc_out <= crc_step(clr_in ? CRC_PRESET : crc_out, byte_in);
      end
      else if (clr_in)
      begin
        crc_out <= CRC_PRESET;
      end
    end
  end

endmodule

// [test/ppip_host_monitor.sv]
/*
  port-level checker for the parameter page host block.
  assumes one clock domain and the active-high asynchronous reset of the block.
*/
`timescale 1ns/1ps
module ppip_host_monitor (
  // clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rd_data_out,
  // byte stream
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  // summary
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic pass_out,
  input wire ppip_pkg::ppip_caps_s caps_out
);
  import ppip_pkg::*;
  logic start_wr;
  assign start_wr = ce_in && wr_in && (addr_in == REG_CTRL) && wr_data_in[CTRL_START_BIT];
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  // ==========================================================
  // relations
  a_read_idle_zero: assert property (ce_in && !rd_in |=> rd_data_out == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_start_sets_busy: assert property (start_wr |=> busy_out && !pass_out)
    else $error("start did not raise busy and clear pass");
  a_done_one_cycle: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  a_done_ends_busy: assert property (done_out |-> !busy_out && $past(busy_out))
    else $error("done without a finished pass");
  a_done_after_byte: assert property (done_out |-> $past(byte_valid_in) || $past(byte_valid_in, 2))
    else $error("done not tied to the last byte");
  a_pass_with_done: assert property ($rose(pass_out) |-> done_out)
    else $error("pass rose outside done");
  a_caps_on_pass: assert property ($changed(caps_out) |-> done_out && pass_out)
    else $error("caps changed outside a passing finish");
  a_busy_falls_done: assert property ($fell(busy_out) |-> done_out)
    else $error("busy fell without done");
  c_pass_done: cover property (done_out && pass_out);
  c_fail_done: cover property (done_out && !pass_out);
  c_start: cover property (start_wr);
endmodule
bind ppip_host ppip_host_monitor u_mon (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
  .byte_valid_in(byte_valid_in), .byte_in(byte_in), .busy_out(busy_out), .done_out(done_out),
  .pass_out(pass_out), .caps_out(caps_out));

// [test/ppip_target_model.sv]
/*
  behavioural flash target that streams parameter page copies and an extended page.
  assumes the bench builds a page, then calls send with the byte count.
*/
`timescale 1ns/1ps
module ppip_target_model (
  // clock
  input wire logic core_clk_in,
  // byte stream to the host
  output logic byte_valid_out,
  output logic [7:0] byte_out
);
  import ppip_pkg::*;
  logic [7:0] mem [0:1279];
  initial
  begin
    byte_valid_out = 1'b0;
    byte_out = 8'h00;
  end
  // ==========================================================
  // checksum, msb of each byte first
  function automatic logic [15:0] crc16(input int first, input int last);
    logic [15:0] c;
    c = CRC_PRESET;
    for (int i = first; i <= last; i++)
      for (int b = 7; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ mem[i][b]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  // ==========================================================
  // builders; each copy is made on its own, never replayed
  task automatic build_copy(input int k, input int sm, input bit bad);
    int b;
    logic [15:0] c;
    b = 256 * k;
    for (int i = 0; i < 256; i++)
      mem[b + i] = 8'(i * 7 + 1);
    for (int i = 0; i < 4; i++)
      mem[b + i] = (i < sm) ? PAGE_SIG[8 * i +: 8] : 8'h00;
    mem[b + 151] = 8'h07;
    mem[b + 152] = 8'h34;
    mem[b + 153] = 8'h12;
    mem[b + 164] = 8'h78;
    mem[b + 165] = 8'h56;
    c = crc16(b, b + 253);
    mem[b + 254] = c[7:0];
    mem[b + 255] = c[15:8];
    // a bad copy is damaged after its checksum was stored
    if (bad)
      mem[b + 10] = ~mem[b + 10];
  endtask
  task automatic build_ext(input int len, input logic [7:0] t0, input logic [7:0] t1, input int sm);
    int base;
    logic [15:0] c;
    for (int i = 0; i < len; i++)
      mem[i] = 8'h00;
    for (int i = 0; i < 4; i++)
      mem[2 + i] = (i < sm) ? EXT_SIG[8 * i +: 8] : 8'h00;
    mem[16] = t0;
    mem[17] = 8'h01;
    mem[18] = t1;
    mem[19] = (t1 != SEC_NONE) ? 8'h01 : 8'h00;
    for (int s = 0; s < 2; s++)
    begin
      base = 32 + 16 * s;
      for (int i = 0; i < 8; i++)
        if (((s == 0) ? t0 : t1) == SEC_ECC)
          mem[base + i] = 8'(8'h11 + i);
      if (((s == 0) ? t0 : t1) == SEC_SPEC)
      begin
        mem[base] = 8'h03;
        mem[base + 1] = 8'h01;
      end
    end
    c = crc16(2, len - 1);
    mem[0] = c[7:0];
    mem[1] = c[15:8];
  endtask
  // ==========================================================
  // streaming; a released line shows the inverse of the last byte
  task automatic send(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk_in);
      byte_valid_out <= 1'b1;
      byte_out <= mem[i];
    end
    @(posedge core_clk_in);
    byte_valid_out <= 1'b0;
    byte_out <= ~mem[n - 1];
  endtask
endmodule

// [test/tb_top.sv]
/*
  self-checking bench for the parameter page host block.
  assumes the target model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module tb_top;
  import ppip_pkg::*;
  localparam logic [7:0] ET0 [4] = '{8'h02, 8'h01, 8'h02, 8'h02};
  localparam logic [7:0] ET1 [4] = '{8'h00, 8'h02, 8'h01, 8'h00};
  localparam logic [31:0] ES [4] = '{32'h4, 32'h4, 32'h24, 32'h8};
  logic core_clk_in, rst_in, ce_in, wr_in, rd_in, byte_valid, busy_out, done_out, pass_out;
  logic [7:0] addr_in, byte_data;
  logic [31:0] wr_data_in, rd_data_out;
  ppip_caps_s caps_out;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int len;
  ppip_host u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
    .byte_valid_in(byte_valid), .byte_in(byte_data), .busy_out(busy_out), .done_out(done_out),
    .pass_out(pass_out), .caps_out(caps_out));
  ppip_target_model u_tgt (.core_clk_in(core_clk_in), .byte_valid_out(byte_valid), .byte_out(byte_data));
  always #12.5 core_clk_in = ~core_clk_in;
  // ==========================================================
  // access and comparison tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge core_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1;
    check(what, rd_data_out & m, exp);
  endtask
  task automatic wait_done();
    bit got;
    got = 1'b0;
    for (int i = 0; i < 20 && !got; i++)
    begin
      #1;
      got = (done_out === 1'b1);
      if (!got)
        @(posedge core_clk_in);
    end
    check("done", {31'h0, got}, 32'h1);
    check("busy", {31'h0, busy_out}, 32'h0);
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // hang guard, well above the few thousand cycles the run needs
  always @(posedge core_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    core_clk_in = 1'b0;
    rst_in = 1'b1;
    ce_in = 1'b1;
    addr_in = 8'h00;
    wr_data_in = 32'h0000_0000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rdchk("status reset", REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk("ext len reset", REG_EXT_LEN, 32'h0000_FFFF, {16'h0000, EXT_LEN_RESET});
    rdchk("unmapped", 8'hFC, 32'hFFFF_FFFF, 32'h0000_0000);
    // run r damages copies 0..r-1; copy 3 and up must show enough signature bytes
    for (int r = 0; r < 5; r++)
    begin
      for (int k = 0; k <= r; k++)
        u_tgt.build_copy(k, (k == r && r > 2) ? 5 - r : 4, k < r);
      wr(REG_CTRL, 32'h0000_0001);
      u_tgt.send((r < 4) ? 256 * (r + 1) : 256 * r + 4);
      wait_done();
      check("pass", {31'h0, pass_out}, (r < 4) ? 32'h1 : 32'h0);
      rdchk("pri status", REG_STATUS, 32'h0000_000C, (r < 4) ? 32'h4 : 32'h8);
      if (r < 4)
        rdchk("copy idx", REG_STATUS, 32'h0000_FF00, r << 8);
      if (r == 0)
        rdchk("crc", REG_CRC, 32'hFFFF_FFFF, {2{u_tgt.mem[255], u_tgt.mem[254]}});
    end
    check("drive", {29'h0, caps_out.drive}, 32'h7);
    check("read time", {16'h0, caps_out.read_time}, 32'h1234);
    check("vendor rev", {16'h0, caps_out.vrev}, 32'h5678);
    rdchk("read time reg", REG_RDTIME, 32'h0000_FFFF, 32'h1234);
    for (int r = 0; r < 4; r++)
    begin
      len = (ET1[r] != SEC_NONE) ? 64 : 48;
      u_tgt.build_ext(len, ET0[r], ET1[r], (r == 3) ? 1 : 4);
      wr(REG_EXT_LEN, len);
      wr(REG_CTRL, 32'h0000_0003);
      u_tgt.send(len);
      wait_done();
      rdchk("ext status", REG_STATUS, 32'h0000_00EC, ES[r]);
      if (r < 2)
        rdchk("ecc lo", REG_ECC_LO, 32'hFFFF_FFFF, 32'h1413_1211);
      if (r < 2)
        rdchk("ecc hi", REG_ECC_HI, 32'hFFFF_FFFF, 32'h1817_1615);
      if (r == 1)
        rdchk("section 8", REG_SEC8, 32'h0000_FFFF, 32'h0000_0103);
    end
    rdchk("ctrl mode", REG_CTRL, 32'h0000_0002, 32'h0000_0002);
    // a start written while the enable is low must be ignored
    ce_in <= 1'b0;
    wr(REG_CTRL, 32'h0000_0001);
    #1;
    check("frozen busy", {31'h0, busy_out}, 32'h0);
    ce_in <= 1'b1;
    conclude();
  end
endmodule
